// ### hw/volt_monitor_irq.sv
/*
  Interrupt and status logic of the supply-voltage monitor, as an AHB-Lite
  slave. Holds control, condition status, interrupt enable, change flags
  and a factory test register.
  Assumes the comparator outputs arrive asynchronously from the analog part
  and are synchronised here; the analog divider itself lives outside.
*/
// Function
// [R01] High flag set and high enable set requests an interrupt.
// [R02] Low flag set and low enable set requests an interrupt.
// [R03] Any change of the high condition sets the high change flag.
// [R04] Any change of the low condition sets the low change flag.
// [R05] Flags readable anytime; write one clears, zero keeps, nothing else clears.
// [R06] Test register writes ignored outside special mode; reads always allowed.
// [R07] No interrupt request toward the host during stop mode.
// [R08] Stop mode entry or exit leaves both change flags unchanged.
// [R09] Both sense enables clear forces both condition outputs to zero.
// [R10] Software disables interrupt enables before turning sensing off.
// [R11] Enabled low and high requests OR into one interrupt output.
// [R12] Two-bit low select picks one of four low levels.
// [R13] High select bit picks one of two high levels.
// [R14] Software enables sensing on one pin before using interrupts.
// [R15] Setting the sense-pin enable clears the supply-pin enable.
// [R16] Supply-pin enable accepts one only while sense-pin enable is zero.
// [R17] Software treats measurements as invalid while sensing settles.
// [R18] After reset enables, flags and unused upper bits read zero.
`timescale 1ns/1ps
`default_nettype none

module volt_monitor_irq (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Analog comparator results, asynchronous.
  input wire logic low_compare,
  input wire logic high_compare,
  // Chip modes.
  input wire logic special_mode,
  input wire logic stop_mode,
  // Analog control outputs.
  output logic sense_pin_level_enable,
  output logic supply_pin_level_enable,
  output logic [1:0] low_threshold_select,
  output logic high_threshold_select,
  // Interrupt to the host interrupt controller.
  output logic monitor_interrupt
);

  logic [7:0] ctrl;
  logic [1:0] monitor_irq_enable;
  logic [1:0] monitor_irq_flags;
  logic [7:0] test_reg;
  logic [1:0] cmp_meta;
  logic [1:0] cmp_sync;
  logic low_condition;
  logic high_condition;
  logic low_condition_q;
  logic high_condition_q;
  logic wr_pending;
  logic [7:0] wr_addr;
  logic [1:0] next_flags;
  logic [7:0] next_ctrl;
  logic [7:0] wdata8;
  logic low_condition_interrupt;
  logic high_condition_interrupt;
  logic sensing_on;

  assign wdata8 = hwdata[7:0];
  assign sensing_on = ctrl[volt_monitor_pkg::sense_en_bit] | ctrl[volt_monitor_pkg::supply_en_bit];

  // Two-flop synchroniser for the comparator results; only stage two is read.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_meta <= 2'h0;
      cmp_sync <= 2'h0;
    end else begin
      cmp_meta <= {high_compare, low_compare};
      cmp_sync <= cmp_meta;
    end
  end

  // Conditions are forced low while neither pin is sensed.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_condition <= 1'b0;
      high_condition <= 1'b0;
    end else begin
      low_condition <= sensing_on & cmp_sync[0]; // [R09]
      high_condition <= sensing_on & cmp_sync[1]; // [R09]
    end
  end

  // Previous condition values feed the change detectors.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_condition_q <= 1'b0;
      high_condition_q <= 1'b0;
    end else begin
      low_condition_q <= low_condition;
      high_condition_q <= high_condition;
    end
  end

  // Address phase capture; the slave is always ready, so each write lands next cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      wr_addr <= 8'h00;
    end else if (hready) begin
      wr_pending <= hsel & htrans[1] & hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // Control write: sense-pin enable wins over the supply-pin enable.
  always_comb begin
    next_ctrl = ctrl;
    if (wr_pending && wr_addr == volt_monitor_pkg::ctrl_offset) begin
      next_ctrl = wdata8 & volt_monitor_pkg::ctrl_write_mask;
      if (wdata8[volt_monitor_pkg::sense_en_bit]) begin
        next_ctrl[volt_monitor_pkg::supply_en_bit] = 1'b0; // [R15]
      end else if (ctrl[volt_monitor_pkg::sense_en_bit]) begin
        next_ctrl[volt_monitor_pkg::supply_en_bit] = 1'b0; // [R16]
      end
    end
  end

  // Control register drives the analog part directly.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= volt_monitor_pkg::ctrl_reset;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // Interrupt enables, two bits, upper bits stay zero.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      monitor_irq_enable <= volt_monitor_pkg::irq_enable_reset; // [R18]
    end else if (wr_pending && wr_addr == volt_monitor_pkg::irq_enable_offset) begin
      monitor_irq_enable <= wdata8[1:0];
    end
  end

  // Change flags: a change in the clearing cycle keeps its flag set. Stop mode is
  // not looked at here, so the flags survive entry and exit untouched.
  always_comb begin
    next_flags = monitor_irq_flags;
    if (wr_pending && wr_addr == volt_monitor_pkg::irq_flags_offset) begin
      next_flags = monitor_irq_flags & ~wdata8[1:0]; // [R05]
    end
    if (low_condition != low_condition_q) begin
      next_flags[volt_monitor_pkg::low_bit] = 1'b1; // [R04]
    end
    if (high_condition != high_condition_q) begin
      next_flags[volt_monitor_pkg::high_bit] = 1'b1; // [R03]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      monitor_irq_flags <= volt_monitor_pkg::irq_flags_reset; // [R18]
    end else begin
      monitor_irq_flags <= next_flags; // [R08]
    end
  end

  // Factory test register; writes only land in special mode.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      test_reg <= volt_monitor_pkg::test_reset;
    end else if (wr_pending && wr_addr == volt_monitor_pkg::test_offset && special_mode) begin
      test_reg <= wdata8; // [R06]
    end
  end

  assign low_condition_interrupt = monitor_irq_flags[volt_monitor_pkg::low_bit]
    & monitor_irq_enable[volt_monitor_pkg::low_bit]; // [R02]
  assign high_condition_interrupt = monitor_irq_flags[volt_monitor_pkg::high_bit]
    & monitor_irq_enable[volt_monitor_pkg::high_bit]; // [R01]

  // Interrupt output, registered and held off in stop mode.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      monitor_interrupt <= 1'b0;
    end else begin
      monitor_interrupt <= (low_condition_interrupt | high_condition_interrupt) & ~stop_mode; // [R11] [R07]
    end
  end

  // Read data is registered in the address phase so it stands in the data phase.
  // Reading next_ctrl and next_flags forwards a write still in its data phase to a read right behind it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        volt_monitor_pkg::ctrl_offset: hrdata <= {24'h000000, next_ctrl};
        volt_monitor_pkg::status_offset: hrdata <= {30'h00000000, high_condition, low_condition};
        volt_monitor_pkg::irq_enable_offset: hrdata <= {30'h00000000, monitor_irq_enable};
        volt_monitor_pkg::irq_flags_offset: hrdata <= {30'h00000000, next_flags};
        volt_monitor_pkg::test_offset: hrdata <= {24'h000000, test_reg};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // Zero-wait slave with OKAY only; flops keep the outputs registered.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign sense_pin_level_enable = ctrl[volt_monitor_pkg::sense_en_bit];
  assign supply_pin_level_enable = ctrl[volt_monitor_pkg::supply_en_bit];
  assign low_threshold_select = ctrl[volt_monitor_pkg::low_sel_lsb +: 2]; // [R12]
  assign high_threshold_select = ctrl[volt_monitor_pkg::high_sel_bit]; // [R13]

  // A condition change sets its flag one cycle later, even against a clearing write.
  chk_low_change_flag: assert property (@(posedge hclk) disable iff (!hresetn) // [R04]
    $changed(low_condition) |=> monitor_irq_flags[0]) else $error("low change did not set flag");
  chk_high_change_flag: assert property (@(posedge hclk) disable iff (!hresetn) // [R03]
    $changed(high_condition) |=> monitor_irq_flags[1]) else $error("high change did not set flag");
  chk_flag_clear_only: assert property (@(posedge hclk) disable iff (!hresetn) // [R05]
    $fell(monitor_irq_flags[0]) |-> $past(wr_pending)
      && $past(wr_addr) == volt_monitor_pkg::irq_flags_offset && $past(hwdata[0]))
    else $error("low flag cleared without write one");

  // The high flag, like the low one, is only cleared by writing a one to it.
  chk_high_clear_only: assert property (@(posedge hclk) disable iff (!hresetn) // [R05]
    $fell(monitor_irq_flags[volt_monitor_pkg::high_bit]) |-> $past(wr_pending)
      && $past(wr_addr) == volt_monitor_pkg::irq_flags_offset && $past(hwdata[volt_monitor_pkg::high_bit]))
    else $error("high flag cleared without write one");

  // Flags move only by a detected change or a flag write, so stop mode cannot touch them.
  chk_flags_change_cause: assert property (@(posedge hclk) disable iff (!hresetn) // [R08]
    $changed(monitor_irq_flags) |-> $past(wr_pending && wr_addr == volt_monitor_pkg::irq_flags_offset)
      || $past(low_condition != low_condition_q) || $past(high_condition != high_condition_q))
    else $error("flags changed without cause");

  // Interrupt gating against the enables and stop mode.
  chk_irq_or_join: assert property (@(posedge hclk) disable iff (!hresetn) // [R11]
    monitor_interrupt == $past((monitor_irq_flags & monitor_irq_enable) != 2'h0 && !stop_mode))
    else $error("interrupt not the enabled flag OR");
  chk_stop_no_irq: assert property (@(posedge hclk) disable iff (!hresetn) // [R07]
    stop_mode ##1 stop_mode |-> !monitor_interrupt) else $error("interrupt in stop mode");
  chk_high_enable_off: assert property (@(posedge hclk) disable iff (!hresetn) // [R01]
    !monitor_irq_enable[1] && !monitor_irq_flags[0] |=> !monitor_interrupt) else $error("masked high request");
  chk_low_enable_off: assert property (@(posedge hclk) disable iff (!hresetn) // [R02]
    !monitor_irq_enable[0] && !monitor_irq_flags[1] |=> !monitor_interrupt) else $error("masked low request");

  // Sensing, pin choice, test lock and read-back.
  chk_sense_off_zero: assert property (@(posedge hclk) disable iff (!hresetn) // [R09]
    !sensing_on ##1 !sensing_on |-> !low_condition && !high_condition) else $error("condition while sensing off");
  chk_one_pin_only: assert property (@(posedge hclk) disable iff (!hresetn) // [R15]
    !(sense_pin_level_enable && supply_pin_level_enable)) else $error("both pins sensed");
  chk_test_locked: assert property (@(posedge hclk) disable iff (!hresetn) // [R06]
    !special_mode |=> $stable(test_reg)) else $error("test register written outside special mode");
  chk_flags_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn) // [R18]
    hready && hsel && htrans[1] && !hwrite |=> hrdata[31:8] == 24'h000000) else $error("upper bits not zero");

  // A control write with the sense-pin enable set always leaves the supply pin off.
  chk_sense_wins: assert property (@(posedge hclk) disable iff (!hresetn) // [R15]
    wr_pending && wr_addr == volt_monitor_pkg::ctrl_offset && wdata8[volt_monitor_pkg::sense_en_bit]
      |=> sense_pin_level_enable && !supply_pin_level_enable) else $error("sense enable did not win");

  // While the sense pin is on, a control write cannot switch the supply pin on.
  chk_supply_refused: assert property (@(posedge hclk) disable iff (!hresetn) // [R16]
    wr_pending && wr_addr == volt_monitor_pkg::ctrl_offset && sense_pin_level_enable
      |=> !supply_pin_level_enable) else $error("supply enable accepted while sense on");

  // Threshold selects follow the last control write field for field.
  chk_low_select: assert property (@(posedge hclk) disable iff (!hresetn) // [R12]
    wr_pending && wr_addr == volt_monitor_pkg::ctrl_offset
      |=> low_threshold_select == $past(wdata8[volt_monitor_pkg::low_sel_lsb +: 2]))
    else $error("low select wrong");
  chk_high_select: assert property (@(posedge hclk) disable iff (!hresetn) // [R13]
    wr_pending && wr_addr == volt_monitor_pkg::ctrl_offset
      |=> high_threshold_select == $past(wdata8[volt_monitor_pkg::high_sel_bit]))
    else $error("high select wrong");

  // Main scenarios: each source raising the interrupt, a clear, stop mode and a refused pin write.
  cov_low_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(monitor_interrupt) && monitor_irq_flags[0]);
  cov_high_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(monitor_interrupt) && monitor_irq_flags[1]);
  cov_flag_clear: cover property (@(posedge hclk) disable iff (!hresetn) $fell(monitor_irq_flags[1]));
  cov_stop_held: cover property (@(posedge hclk) disable iff (!hresetn) stop_mode && (monitor_irq_flags & monitor_irq_enable) != 2'h0);
  cov_supply_refused: cover property (@(posedge hclk) disable iff (!hresetn) wr_pending
    && wr_addr == volt_monitor_pkg::ctrl_offset && sense_pin_level_enable && wdata8[volt_monitor_pkg::supply_en_bit]);

endmodule // volt_monitor_irq

`default_nettype wire

// ### hw/volt_monitor_pkg.sv
/*
  Package for the supply-voltage monitor interrupt block: register byte
  offsets, field positions and reset values.
  Assumes a 32-bit AHB-Lite register bus, one aligned word per register.
*/
package volt_monitor_pkg;

  // Register byte offsets.
  localparam logic [7:0] ctrl_offset = 8'h00;
  localparam logic [7:0] status_offset = 8'h04;
  localparam logic [7:0] irq_enable_offset = 8'h08;
  localparam logic [7:0] irq_flags_offset = 8'h0C;
  localparam logic [7:0] test_offset = 8'h10;

  // Control register fields.
  localparam int sense_en_bit = 0;
  localparam int supply_en_bit = 2;
  localparam int low_sel_lsb = 4;
  localparam int high_sel_bit = 6;
  // Writable control bits; every other control bit reads zero.
  localparam logic [7:0] ctrl_write_mask = 8'h75;

  // Enable, flag and status register fields.
  localparam int low_bit = 0;
  localparam int high_bit = 1;

  // Reset values.
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [1:0] irq_enable_reset = 2'h0;
  localparam logic [1:0] irq_flags_reset = 2'h0;
  localparam logic [7:0] test_reset = 8'h00;

endpackage

// ### verification/volt_sense_model.sv
/*
  Behavioural model of the analog comparators in front of the monitor.
  Assumes the bench sets the measured level in plain units and the block
  drives the sense enables and threshold selects.
*/
`timescale 1ns/1ps
`default_nettype none
module volt_sense_model #(
  parameter int low_lvl [4] = '{60, 70, 80, 90},
  parameter int high_lvl [2] = '{160, 180}
) (
  // Measured level and block controls.
  input wire logic [7:0] level,
  input wire logic sense_en,
  input wire logic supply_en,
  input wire logic [1:0] low_sel,
  input wire logic high_sel,
  // Comparator results.
  output logic low_compare,
  output logic high_compare
);
  // A disconnected divider yields no comparison at all.
  assign low_compare = (sense_en | supply_en) && (int'(level) < low_lvl[low_sel]);
  assign high_compare = (sense_en | supply_en) && (int'(level) >= high_lvl[high_sel]);
endmodule // volt_sense_model
`default_nettype wire

// ### verification/volt_monitor_irq_tb.sv
/*
  Self-checking bench for the monitor interrupt block over AHB-Lite.
  Assumes the comparator model above and a zero-wait slave.
*/
`timescale 1ns/1ps
`default_nettype none
module volt_monitor_irq_tb;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, special_mode = 1'b0, stop_mode = 1'b0;
  logic low_compare, high_compare, sense_en, supply_en, high_sel, irq;
  logic [1:0] low_sel;
  logic [7:0] level = 8'h78;
  int mismatches = 0, cmp_count = 0;
  // Half period of 50 ns gives 10 MHz.
  always #50 hclk = ~hclk;
  volt_monitor_irq i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .low_compare(low_compare), .high_compare(high_compare),
    .special_mode(special_mode), .stop_mode(stop_mode), .sense_pin_level_enable(sense_en),
    .supply_pin_level_enable(supply_en), .low_threshold_select(low_sel),
    .high_threshold_select(high_sel), .monitor_interrupt(irq));
  volt_sense_model i_model (.level(level), .sense_en(sense_en), .supply_en(supply_en), .low_sel(low_sel),
    .high_sel(high_sel), .low_compare(low_compare), .high_compare(high_compare));
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Waits for hready under a bound; a stuck bus ends the run.
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        check("hready wait", 32'h0, 32'h1);
        tally_and_finish();
      end
      @(posedge hclk);
    end
  endtask
  // One single word transfer: address phase, then data phase.
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    haddr <= {24'h0, addr};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    check("bus response", {31'h0, hresp}, 32'h0);
  endtask
  task automatic rreg(input string what, input logic [7:0] addr, input logic [31:0] exp);
    bus(1'b0, addr, 32'h0);
    check(what, rd, exp);
  endtask
  // Six edges cover synchroniser, condition, flag and interrupt stages plus the settling time.
  task automatic settle(input logic [7:0] lv);
    level <= lv;
    repeat (6) @(posedge hclk);
  endtask
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rreg("enable", volt_monitor_pkg::irq_enable_offset, 32'h0);
    rreg("flags", volt_monitor_pkg::irq_flags_offset, 32'h0);
    bus(1'b1, volt_monitor_pkg::ctrl_offset, 32'h4);
    rreg("ctrl", volt_monitor_pkg::ctrl_offset, 32'h4);
    check("pin enables", {30'h0, supply_en, sense_en}, 32'h2);
    bus(1'b1, volt_monitor_pkg::ctrl_offset, 32'h5);
    rreg("ctrl", volt_monitor_pkg::ctrl_offset, 32'h1);
    check("pin enables", {30'h0, supply_en, sense_en}, 32'h1);
    bus(1'b1, volt_monitor_pkg::ctrl_offset, 32'h4);
    rreg("ctrl", volt_monitor_pkg::ctrl_offset, 32'h0);
    for (int s = 0; s < 8; s++) begin
      bus(1'b1, volt_monitor_pkg::ctrl_offset, {25'h0, s[2:0], 4'h1});
      // The control register takes the write at the data-phase edge; look one edge later.
      @(posedge hclk);
      check("selects", {29'h0, high_sel, low_sel}, {29'h0, s[2:0]});
    end
    bus(1'b1, volt_monitor_pkg::ctrl_offset, 32'h1);
    settle(8'h55);
    rreg("flags", volt_monitor_pkg::irq_flags_offset, 32'h0);
    bus(1'b1, volt_monitor_pkg::ctrl_offset, 32'h31);
    settle(8'h55);
    rreg("status", volt_monitor_pkg::status_offset, 32'h1);
    check("irq masked", {31'h0, irq}, 32'h0);
    bus(1'b1, volt_monitor_pkg::irq_enable_offset, 32'h1);
    settle(8'h78);
    check("irq low", {31'h0, irq}, 32'h1);
    rreg("flags", volt_monitor_pkg::irq_flags_offset, 32'h1);
    bus(1'b1, volt_monitor_pkg::irq_flags_offset, 32'h0);
    rreg("flags kept", volt_monitor_pkg::irq_flags_offset, 32'h1);
    bus(1'b1, volt_monitor_pkg::irq_flags_offset, 32'h1);
    settle(8'h78);
    rreg("flags clear", volt_monitor_pkg::irq_flags_offset, 32'h0);
    check("irq off", {31'h0, irq}, 32'h0);
    bus(1'b1, volt_monitor_pkg::irq_enable_offset, 32'h2);
    settle(8'hB4);
    check("irq high", {31'h0, irq}, 32'h1);
    stop_mode <= 1'b1;
    settle(8'hB4);
    check("irq stop", {31'h0, irq}, 32'h0);
    stop_mode <= 1'b0;
    settle(8'hB4);
    check("irq run", {31'h0, irq}, 32'h1);
    rreg("flags stop", volt_monitor_pkg::irq_flags_offset, 32'h2);
    bus(1'b1, volt_monitor_pkg::irq_flags_offset, 32'h3);
    bus(1'b1, volt_monitor_pkg::irq_enable_offset, 32'h0);
    bus(1'b1, volt_monitor_pkg::ctrl_offset, 32'h0);
    settle(8'hB4);
    rreg("status off", volt_monitor_pkg::status_offset, 32'h0);
    rreg("flags off", volt_monitor_pkg::irq_flags_offset, 32'h2);
    check("irq quiet", {31'h0, irq}, 32'h0);
    bus(1'b1, volt_monitor_pkg::test_offset, 32'h5A);
    rreg("test normal", volt_monitor_pkg::test_offset, 32'h0);
    special_mode <= 1'b1;
    bus(1'b1, volt_monitor_pkg::test_offset, 32'h5A);
    rreg("test special", volt_monitor_pkg::test_offset, 32'h5A);
    bus(1'b1, volt_monitor_pkg::irq_enable_offset, 32'hFF);
    rreg("enable upper", volt_monitor_pkg::irq_enable_offset, 32'h3);
    // A second reset in mid-run, with a flag and both enables set, while the bus is idle.
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rreg("enable reset", volt_monitor_pkg::irq_enable_offset, 32'h0);
    rreg("flags reset", volt_monitor_pkg::irq_flags_offset, 32'h0);
    check("irq reset", {31'h0, irq}, 32'h0);
    rreg("unmapped", 8'h20, 32'h0);
    tally_and_finish();
  end
endmodule // volt_monitor_irq_tb
`default_nettype wire
